//--- pkg/ltcap_pkg.sv
// ==========================================================================
// Lifetime timer constants
package ltcap_pkg;

  // ========================================================================
  // Control word field positions and reset value
  localparam int          CTL_CAP_EN_BIT = 17;
  localparam int          CTL_ES_LSB     = 12;
  localparam int          CTL_CLK_LSB    = 9;
  localparam int          CTL_UP_BIT     = 8;
  localparam int          CTL_EN_BIT     = 7;
  localparam int          CTL_PER_BIT    = 6;
  localparam int          CTL_FMT_LSB    = 4;
  localparam int          CTL_PRE_LSB    = 0;
  localparam logic [31:0] CTL_RESET      = 32'h0000_0000;
  localparam logic [31:0] CTL_MASK       = 32'h0003_f7ff;

  // ========================================================================
  // Clock source codes
  localparam logic [1:0] CLK_OSC32   = 2'h0;
  localparam logic [1:0] CLK_UNDIV   = 2'h1;
  localparam logic [1:0] CLK_XTAL32  = 2'h2;
  localparam logic [1:0] CLK_CORE    = 2'h3;

  // ========================================================================
  // Prescaler codes and division limits (terminal prescale count)
  localparam logic [3:0]  PRE_DIV1     = 4'h0;
  localparam logic [3:0]  PRE_DIV16    = 4'h4;
  localparam logic [3:0]  PRE_DIV256   = 4'h8;
  localparam logic [3:0]  PRE_DIV32768 = 4'hf;
  localparam int          PRE_W        = 15;
  localparam logic [14:0] PRE_LIM1     = 15'h0000;
  localparam logic [14:0] PRE_LIM16    = 15'h000f;
  localparam logic [14:0] PRE_LIM256   = 15'h00ff;
  localparam logic [14:0] PRE_LIM32768 = 15'h7fff;

  // ========================================================================
  // Count formats, selected by control bits [5:4]
  localparam logic [1:0] FMT_BIN16  = 2'h0;
  localparam logic [1:0] FMT_BIN48  = 2'h1;
  localparam logic [1:0] FMT_TOD24  = 2'h2;
  localparam logic [1:0] FMT_TOD256 = 2'h3;

  // ========================================================================
  // Counter limits and time-of-day fields
  localparam logic [15:0] CNT16_MAX  = 16'hffff;
  localparam logic [47:0] CNT48_MAX  = 48'hffff_ffff_ffff;
  localparam logic [6:0]  FRAC_MAX   = 7'h7f;
  localparam logic [5:0]  MINSEC_MAX = 6'h3b;
  localparam logic [7:0]  HR24_MAX   = 8'h17;
  localparam logic [7:0]  HR256_MAX  = 8'hff;

  // ========================================================================
  // Event selection
  localparam int         EV_COUNT    = 18;
  localparam logic [4:0] EV_CODE_MAX = 5'h11;

endpackage : ltcap_pkg

//--- rtl/ltcap_timer.sv
// Overview of operation
// - Free running: restart from maximum or minimum after reaching zero or full scale.
// - Periodic: 16-bit and time-of-day counts restart from the load value held at that moment.
// - Count is visible at any time without disturbing counting.
// - A control write configures the timer; its enable bit starts it.
// - Interrupt asserts on the step after count reaches zero down or full scale up, as the count restarts.
// - A write to the clear register drops the pending interrupt unless a terminal step sets it in the same cycle.
// - Five-bit event code picks capture source; code 17 is external interrupt zero.
// - Time-of-day layout: hours, minutes, seconds, 1/128; gaps read zero.
// - Fractions roll at 127, seconds and minutes at 59, hours 23 or 255.
// - 48-bit up or 16-bit up/down; prescale by 1, 16, 256, 32768.
// - Clock source: core, undivided core, internal or external 32 kHz.
// - 48-bit mode counts up from zero; value split low 16, high 32.
// - 16-bit mode counts up or down; load value loads the counter.
// - Capture copies count on first assertion of source; counter keeps running.
// - Reload on overflow and immediately on clear write.
// - Bit 17 enables capture, bits 16 to 12 hold the event code.
// - Bits 10 to 9 select the clock source.
// - Bits 3 to 0 select the prescaler, divide by 1 default.
// - Bit 7 enable, 6 periodic, 4 48-bit, 8 count up; reset zero.
`timescale 1ns/100ps
`default_nettype none

module ltcap_timer
  import ltcap_pkg::*;
(
  // Clock, reset and clock enable
  input  wire logic                REF_CLK,
  input  wire logic                RESET_N,
  input  wire logic                CLK_EN,
  // Source clock ticks, one core cycle each
  input  wire logic                UNDIV_TICK,
  input  wire logic                OSC32_TICK,
  input  wire logic                XTAL32_TICK,
  // Control register write and readback
  input  wire logic [31:0]         CTRL_WDATA,
  input  wire logic                CTRL_WR,
  output logic      [31:0]         CTRL_RDATA,
  // Load register write and readback
  input  wire logic [15:0]         LOAD_WDATA,
  input  wire logic                LOAD_WR,
  output logic      [15:0]         LOAD_RDATA,
  // Interrupt clear register write strobe
  input  wire logic                CLEAR_WR,
  // Capture sources, index equals event code
  input  wire logic [EV_COUNT-1:0] IRQ_SOURCES,
  // Value, capture and interrupt outputs
  output logic      [15:0]         COUNT_LOW,
  output logic      [31:0]         COUNT_HIGH,
  output logic      [15:0]         CAPTURE_VALUE,
  output logic                     TIMER_IRQ
);

  // ========================================================================
  // Helper functions
  // Prescaler terminal count; undefined codes fall back to divide by 1
  function automatic logic [PRE_W-1:0] pre_limit(input logic [3:0] code);
    case (code)
      PRE_DIV16:    pre_limit = PRE_LIM16;
      PRE_DIV256:   pre_limit = PRE_LIM256;
      PRE_DIV32768: pre_limit = PRE_LIM32768;
      default:      pre_limit = PRE_LIM1;
    endcase
  endfunction : pre_limit

  // Time-of-day increment, carries ripple through fields
  function automatic logic [31:0] tod_step(input logic [31:0] t, input logic [7:0] hmax);
    logic [31:0] r;
    r = t;
    if (t[6:0] != FRAC_MAX) begin
      r[6:0] = t[6:0] + 7'h01;
    end else begin
      r[6:0] = 7'h00;
      if (t[13:8] != MINSEC_MAX) begin
        r[13:8] = t[13:8] + 6'h01;
      end else begin
        r[13:8] = 6'h00;
        if (t[21:16] != MINSEC_MAX) begin
          r[21:16] = t[21:16] + 6'h01;
        end else begin
          r[21:16] = 6'h00;
          r[31:24] = (t[31:24] == hmax) ? 8'h00 : t[31:24] + 8'h01;
        end
      end
    end
    tod_step = r;
  endfunction : tod_step

  // Time-of-day terminal value for the selected hour range
  function automatic logic [31:0] tod_last(input logic [7:0] hmax);
    tod_last = {hmax, 2'h0, MINSEC_MAX, 2'h0, MINSEC_MAX, 1'b0, FRAC_MAX};
  endfunction : tod_last

  // ========================================================================
  // State
  logic [31:0]         timer_control_reg;
  logic [15:0]         reload_value_reg;
  logic [47:0]         count;
  logic [PRE_W-1:0]    pre_cnt;
  logic [15:0]         capture_value_reg;
  logic                irq;
  logic [EV_COUNT-1:0] src_prev;
  logic [31:0]         next_ctrl;
  logic [15:0]         next_load;
  logic [47:0]         next_count;
  logic [PRE_W-1:0]    next_pre;
  logic [15:0]         next_cap;
  logic                next_irq;

  // Decoded control fields
  logic        en;
  logic        periodic;
  logic        up;
  logic        cap_en;
  logic [1:0]  fmt;
  logic [1:0]  clk_sel;
  logic [4:0]  ev_code;
  logic [7:0]  hmax;
  logic        src_tick;
  logic        step;
  logic        at_end;
  logic [47:0] restart;
  logic        ev_rise;

  // ========================================================================
  // Field decode and event detection
  always_comb begin
    en       = timer_control_reg[CTL_EN_BIT];
    periodic = timer_control_reg[CTL_PER_BIT];
    up       = timer_control_reg[CTL_UP_BIT];
    cap_en   = timer_control_reg[CTL_CAP_EN_BIT];
    fmt      = timer_control_reg[CTL_FMT_LSB +: 2];
    clk_sel  = timer_control_reg[CTL_CLK_LSB +: 2];
    ev_code  = timer_control_reg[CTL_ES_LSB +: 5];
    hmax     = (fmt == FMT_TOD24) ? HR24_MAX : HR256_MAX;
    case (clk_sel)
      CLK_OSC32:  src_tick = OSC32_TICK;
      CLK_UNDIV:  src_tick = UNDIV_TICK;
      CLK_XTAL32: src_tick = XTAL32_TICK;
      default:    src_tick = 1'b1;
    endcase
    step = en && src_tick && (pre_cnt == pre_limit(timer_control_reg[CTL_PRE_LSB +: 4]));
    case (fmt)
      FMT_BIN16: begin
        at_end  = up ? (count[15:0] == CNT16_MAX) : (count[15:0] == 16'h0000);
        restart = periodic ? {32'h0, reload_value_reg} : (up ? 48'h0 : {32'h0, CNT16_MAX});
      end
      FMT_BIN48: begin
        at_end  = (count == CNT48_MAX);
        restart = 48'h0;
      end
      default: begin
        at_end  = (count[31:0] == tod_last(hmax));
        restart = periodic ? {32'h0, reload_value_reg} : 48'h0;
      end
    endcase
    ev_rise = (ev_code <= EV_CODE_MAX) && IRQ_SOURCES[ev_code] && !src_prev[ev_code];
  end

  // ========================================================================
  // Next-state logic
  always_comb begin
    next_ctrl  = timer_control_reg;
    next_load  = reload_value_reg;
    next_count = count;
    next_pre   = pre_cnt;
    next_cap   = capture_value_reg;
    next_irq   = irq;
    // Prescaler advances only on source ticks while enabled
    if (en && src_tick) begin
      next_pre = step ? '0 : pre_cnt + 15'h0001;
    end
    // counting never waits on reads; value ports are plain flops
    if (step) begin
      if (at_end) begin
        next_count = restart;
      end else if (fmt == FMT_BIN16) begin
        // up or down in 16-bit mode
        next_count = {32'h0, up ? count[15:0] + 16'h0001 : count[15:0] - 16'h0001};
      end else if (fmt == FMT_BIN48) begin
        next_count = count + 48'h1;
      end else begin
        next_count = {16'h0, tod_step(count[31:0], hmax)};
      end
    end
    // clear drops the request; a same-cycle event below still sets it
    if (CLEAR_WR) begin
      next_irq   = 1'b0;
      next_count = restart;
    end
    // load write goes to the counter as well as the register
    if (LOAD_WR) begin
      next_load  = LOAD_WDATA;
      next_count = {32'h0, LOAD_WDATA};
    end
    // control write configures the timer and clears the prescaler; count cleared only in 48-bit format
    if (CTRL_WR) begin
      next_ctrl  = CTRL_WDATA & CTL_MASK;
      next_pre   = '0;
      next_count = (CTRL_WDATA[CTL_FMT_LSB +: 2] == FMT_BIN48) ? 48'h0 : count;
    end
    // gap bits forced to zero in time-of-day format, whatever was loaded
    if (next_ctrl[CTL_FMT_LSB + 1]) begin
      next_count = next_count & 48'h0000_ff3f_3f7f;
    end
    // interrupt on terminal step, set wins over clear
    if (step && at_end) begin
      next_irq = 1'b1;
    end
    if (cap_en && ev_rise) begin
      next_cap = count[15:0];
    end
  end

  // ========================================================================
  // Registers; clock enable freezes everything
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      // all control bits reset to zero
      timer_control_reg <= CTL_RESET;
      reload_value_reg  <= 16'h0000;
      count             <= 48'h0;
      pre_cnt           <= '0;
      capture_value_reg <= 16'h0000;
      irq               <= 1'b0;
      src_prev          <= '0;
    end else if (CLK_EN) begin
      timer_control_reg <= next_ctrl;
      reload_value_reg  <= next_load;
      count             <= next_count;
      pre_cnt           <= next_pre;
      capture_value_reg <= next_cap;
      irq               <= next_irq;
      src_prev          <= IRQ_SOURCES;
    end
  end

  // ========================================================================
  // Outputs
  // value split into low 16 and high 32 bits
  assign COUNT_LOW     = count[15:0];
  assign COUNT_HIGH    = count[47:16];
  assign CAPTURE_VALUE = capture_value_reg;
  assign TIMER_IRQ     = irq;
  assign CTRL_RDATA    = timer_control_reg;
  assign LOAD_RDATA    = reload_value_reg;

  // ========================================================================
  // Assertions
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);

  a_irq_on_end: assert property (CLK_EN && step && at_end |=> TIMER_IRQ)
    else $error("interrupt missing after terminal count");
  a_clear_drops: assert property (CLK_EN && CLEAR_WR && !(step && at_end) |=> !TIMER_IRQ)
    else $error("clear did not drop interrupt");
  a_free_down_wrap: assert property (CLK_EN && step && at_end && fmt == FMT_BIN16 && !periodic
    && !up && !CLEAR_WR && !LOAD_WR && !CTRL_WR |=> COUNT_LOW == CNT16_MAX)
    else $error("free down count did not restart at maximum");
  a_periodic_wrap: assert property (CLK_EN && step && at_end && fmt == FMT_BIN16 && periodic
    && !CLEAR_WR && !LOAD_WR && !CTRL_WR |=> COUNT_LOW == $past(reload_value_reg))
    else $error("periodic count did not restart from load");
  a_load_writes: assert property (CLK_EN && LOAD_WR && !CTRL_WR
    |=> LOAD_RDATA == $past(LOAD_WDATA)
    && COUNT_LOW == ($past(LOAD_WDATA) & (fmt[1] ? 16'h3f7f : 16'hffff)))
    else $error("load write not applied");
  a_capture_once: assert property (CLK_EN && cap_en && ev_rise |=> CAPTURE_VALUE == $past(COUNT_LOW))
    else $error("capture missed");
  a_capture_hold: assert property (!(cap_en && ev_rise) |=> $stable(CAPTURE_VALUE))
    else $error("capture changed without edge");
  a_tod_fields: assert property (fmt[1] |-> count[23:22] == 2'h0 && count[15:14] == 2'h0
    && count[7] == 1'b0)
    else $error("time-of-day gap bits set");
  a_disabled_hold: assert property (!en && !CLEAR_WR && !LOAD_WR && !CTRL_WR |=> $stable(count))
    else $error("counter moved while disabled");
  a_bin48_up: assert property (CLK_EN && step && !at_end && fmt == FMT_BIN48 && !CLEAR_WR
    && !LOAD_WR && !CTRL_WR |=> count == $past(count) + 48'h1)
    else $error("48-bit count did not step up");

  c_wrap: cover property (step && at_end);
  c_capture: cover property (cap_en && ev_rise);
  c_clear_irq: cover property (TIMER_IRQ ##1 CLEAR_WR);
  c_tod_roll: cover property (fmt[1] && step && count[6:0] == FRAC_MAX);

endmodule : ltcap_timer

`default_nettype wire

//--- verif/ltcap_timer_tb.sv
`timescale 1ns/100ps
`default_nettype none

module ltcap_timer_tb;
  import ltcap_pkg::*;

  // ==========================================================================
  // Stimulus and observation
  logic        REF_CLK     = 1'b0;
  logic        RESET_N     = 1'b0;
  logic        CLK_EN      = 1'b1;
  logic        UNDIV_TICK  = 1'b0;
  logic        OSC32_TICK  = 1'b0;
  logic        XTAL32_TICK = 1'b0;
  logic [31:0] CTRL_WDATA  = 32'h0;
  logic        CTRL_WR     = 1'b0;
  logic [15:0] LOAD_WDATA  = 16'h0;
  logic        LOAD_WR     = 1'b0;
  logic        CLEAR_WR    = 1'b0;
  logic [17:0] IRQ_SOURCES = 18'h0;
  logic [31:0] CTRL_RDATA, COUNT_HIGH;
  logic [15:0] LOAD_RDATA, COUNT_LOW, CAPTURE_VALUE;
  logic        TIMER_IRQ;
  int          n_fail      = 0;
  int          checks_done = 0;
  int          seed        = 32'ha411d92a;
  int          tc          = 0;
  int          n;
  logic [15:0] v;
  logic [31:0] d;
  localparam logic [31:0] EN    = 32'h1 << CTL_EN_BIT;
  localparam logic [31:0] PER   = 32'h1 << CTL_PER_BIT;
  localparam logic [31:0] UP    = 32'h1 << CTL_UP_BIT;
  localparam logic [31:0] CAPEN = 32'h1 << CTL_CAP_EN_BIT;
  localparam logic [31:0] CORE  = 32'(CLK_CORE) << CTL_CLK_LSB;
  // Time-of-day units need the 32 kHz source divided by 256
  localparam logic [31:0] TODCLK = (32'(CLK_OSC32) << CTL_CLK_LSB) | 32'(PRE_DIV256);
  // Wrap cases: periodic down, free down, free up, periodic up
  logic [15:0] lds [4] = '{16'h0040, 16'h0003, 16'hfffc, 16'hfff0};
  logic [31:0] cfg [4] = '{PER, 32'h0, UP, PER | UP};
  // Tick period of each source code, and prescaler codes with their divisors
  int          per [4] = '{5, 2, 7, 1};
  logic [31:0] pre [3] = '{32'(PRE_DIV1), 32'(PRE_DIV16), 32'(PRE_DIV256)};
  int          dv  [3] = '{1, 16, 256};

  always #2 REF_CLK = ~REF_CLK;

  // Slow sources tick on fixed periods so step gaps are predictable
  always @(posedge REF_CLK) begin
    tc          <= tc + 1;
    UNDIV_TICK  <= (tc % 2 == 0);
    OSC32_TICK  <= (tc % 5 == 0);
    XTAL32_TICK <= (tc % 7 == 0);
  end

  ltcap_timer i_ltcap_timer (
    .REF_CLK(REF_CLK), .RESET_N(RESET_N), .CLK_EN(CLK_EN),
    .UNDIV_TICK(UNDIV_TICK), .OSC32_TICK(OSC32_TICK), .XTAL32_TICK(XTAL32_TICK),
    .CTRL_WDATA(CTRL_WDATA), .CTRL_WR(CTRL_WR), .CTRL_RDATA(CTRL_RDATA),
    .LOAD_WDATA(LOAD_WDATA), .LOAD_WR(LOAD_WR), .LOAD_RDATA(LOAD_RDATA),
    .CLEAR_WR(CLEAR_WR), .IRQ_SOURCES(IRQ_SOURCES), .COUNT_LOW(COUNT_LOW),
    .COUNT_HIGH(COUNT_HIGH), .CAPTURE_VALUE(CAPTURE_VALUE), .TIMER_IRQ(TIMER_IRQ)
  );

  // ==========================================================================
  // Helpers
  task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Restart value after a 16-bit wrap, worked out from the mode bits and the load value
  function automatic logic [15:0] wrap_to(input logic [31:0] c, input logic [15:0] ld);
    wrap_to = c[CTL_PER_BIT] ? ld : (c[CTL_UP_BIT] ? 16'h0000 : CNT16_MAX);
  endfunction : wrap_to

  // One strobe: 0 control, 1 load, 2 clear; returns mid-cycle after the take
  task automatic wr(input int k, input logic [31:0] dat);
    @(posedge REF_CLK);
    CTRL_WDATA <= dat;
    LOAD_WDATA <= dat[15:0];
    CTRL_WR    <= (k == 0);
    LOAD_WR    <= (k == 1);
    CLEAR_WR   <= (k == 2);
    @(posedge REF_CLK);
    {CTRL_WR, LOAD_WR, CLEAR_WR} <= 3'h0;
    @(negedge REF_CLK);
  endtask : wr

  // Cycles until the low count moves; bounded so a stuck counter fails
  task automatic wait_chg(output int cnt);
    logic [15:0] old;
    old = COUNT_LOW;
    cnt = 0;
    do begin
      @(negedge REF_CLK);
      cnt++;
    end while (COUNT_LOW === old && cnt < 4000);
    if (cnt >= 4000) n_fail++;
  endtask : wait_chg

  task automatic wait_irq;
    int c;
    c = 0;
    while (TIMER_IRQ !== 1'b1 && c < 4000) begin
      @(negedge REF_CLK);
      c++;
    end
    if (c >= 4000) n_fail++;
  endtask : wait_irq

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  // ==========================================================================
  // Scenarios
  initial begin
    repeat (3) @(posedge REF_CLK);
    RESET_N <= 1'b1;
    @(negedge REF_CLK);
    chk("ctrl_rst", CTRL_RDATA, CTL_RESET);
    chk("load_rst", LOAD_RDATA, 16'h0);
    chk("count_rst", {COUNT_HIGH, COUNT_LOW}, 48'h0);
    chk("cap_rst", {CAPTURE_VALUE, TIMER_IRQ}, 17'h0);
    for (int i = 0; i < 6; i++) begin
      d = $random(seed);
      wr(0, d);
      chk("ctrl_rd", CTRL_RDATA, d & CTL_MASK);
    end
    wr(0, 32'h0);
    d = $random(seed);
    wr(1, d);
    chk("load_rd", {LOAD_RDATA, COUNT_LOW}, {d[15:0], d[15:0]});
    // Disabled timer holds its count
    wr(0, CORE | PER);
    v = COUNT_LOW;
    repeat (5) @(negedge REF_CLK);
    chk("idle", COUNT_LOW, v);
    for (int i = 0; i < 4; i++) begin
      wr(0, 32'h0);
      wr(2, 32'h0);
      wr(1, {16'h0, lds[i]});
      wr(0, EN | CORE | cfg[i]);
      wait_irq();
      chk("wrap_cnt", COUNT_LOW, wrap_to(cfg[i], lds[i]));
      wr(2, 32'h0);
      chk("clr_irq", TIMER_IRQ, 1'b0);
      chk("clr_cnt", COUNT_LOW, wrap_to(cfg[i], lds[i]));
    end
    // Every source against prescalers 1, 16 and 256: gap between steps
    foreach (per[s]) for (int p = 0; p < 3; p++) begin
      wr(0, 32'h0);
      wr(1, 32'h8000);
      wr(0, EN | (32'(s) << CTL_CLK_LSB) | pre[p]);
      wait_chg(n);
      wait_chg(n);
      chk("step_gap", 48'(n), 48'(per[s] * dv[p]));
    end
    wr(0, 32'h0);
    wr(1, 32'h8000);
    // Every event code, with random noise on the other sources
    for (int e = 0; e < EV_COUNT; e++) begin
      wr(0, EN | CORE | CAPEN | (32'(e) << CTL_ES_LSB));
      @(posedge REF_CLK);
      IRQ_SOURCES <= 18'($random(seed)) & ~(18'h1 << e);
      repeat (2) @(posedge REF_CLK);
      IRQ_SOURCES[e] <= 1'b1;
      @(negedge REF_CLK);
      v = COUNT_LOW;
      @(negedge REF_CLK);
      chk("cap_val", CAPTURE_VALUE, v);
      chk("cap_run", COUNT_LOW, v - 16'h1);
      repeat (4) @(negedge REF_CLK);
      chk("cap_once", CAPTURE_VALUE, v);
    end
    wr(0, EN | CORE | (32'h5 << CTL_ES_LSB));
    @(posedge REF_CLK);
    IRQ_SOURCES <= 18'h0;
    repeat (2) @(posedge REF_CLK);
    IRQ_SOURCES <= 18'h3ffff;
    repeat (3) @(negedge REF_CLK);
    chk("cap_off", CAPTURE_VALUE, v);
    // Time-of-day carry from 59 s 127/128 into the next minute
    for (int f = 2; f < 4; f++) begin
      wr(0, 32'h0);
      wr(1, 32'h3b7e);
      wr(0, EN | (f == 3 ? TODCLK : CORE) | (32'(f) << CTL_FMT_LSB));
      wait_chg(n);
      chk("tod_frac", COUNT_LOW, 16'h3b7f);
      wait_chg(n);
      chk("tod_roll", {COUNT_HIGH, COUNT_LOW}, 48'h0000_0001_0000);
    end
    wr(0, EN | CORE | (32'(FMT_BIN48) << CTL_FMT_LSB));
    chk("b48_zero", {COUNT_HIGH, COUNT_LOW}, 48'h0);
    repeat (20) @(negedge REF_CLK);
    chk("b48_up", {COUNT_HIGH, COUNT_LOW}, 48'd20);
    // Clock enable low freezes the count
    @(posedge REF_CLK);
    CLK_EN <= 1'b0;
    repeat (5) @(negedge REF_CLK);
    chk("freeze", {COUNT_HIGH, COUNT_LOW}, 48'd21);
    @(posedge REF_CLK);
    CLK_EN <= 1'b1;
    wr(2, 32'h0);
    chk("b48_clr", {COUNT_HIGH, COUNT_LOW}, 48'h0);
    test_done();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (40000) @(posedge REF_CLK);
    n_fail++;
    test_done();
  end

endmodule : ltcap_timer_tb

`default_nettype wire
